// ### hw/virt_gate_pkg.sv
// package for the virtual-machine feature gate
// assumes a single core clock and synchronous active-low reset
package virt_gate_pkg;
    localparam int feature_bits = 64;
    localparam int vm_feature_pos = 40;
    localparam int vmsw_enable_pos = 54;
    localparam logic [2:0] rights_full = 3'h7;
    localparam logic [feature_bits-1:0] status_reset = 64'h0;
    localparam logic [1:0] status_ok = 2'h0;
    localparam logic [1:0] status_unimpl = 2'h1;

    typedef enum {fault_none, fault_illegal_op, fault_virtualization} fault_type;

    typedef struct packed {
        logic [feature_bits-1:0] avail;
        logic [feature_bits-1:0] status;
        logic [feature_bits-1:0] control;
    } feature_vec_type;

    typedef struct packed {
        logic valid;
        logic most_privileged;
        logic instr_translation_on;
        logic [2:0] instr_tlb_rights;
    } switch_req_type;

    typedef struct packed {
        logic valid;
        logic illegal_op;
        logic virt_fault;
    } switch_resp_type;
endpackage

// ### hw/sticky_disable.sv
// one sticky flag: set by a request, cleared only by reset
// assumes synchronous active-low reset on the core clock
`timescale 1ns/10ps
module sticky_disable (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic set,
    output logic flag
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end
    end
endmodule // sticky_disable

// ### hw/virtual_machine_disable_control.sv
// virtual-machine feature gate: feature report, one-way disable, switch fault decision
// assumes software drives feature writes and switch requests on the core clock
//
// Contract
// - vm feature status 1 means mode bit implemented and features enabled
// - implemented but disabled reports presence 1, state 0
// - not implemented reports presence 0 and state 0
// - writing 0 to controllable vm bit turns the features off
// - disable is permanent; only reset restores it
// - after disable, state and control read 0, presence stays 1
// - switch instruction without mode bit raises illegal-operation fault
// - mode bit present but vm or switch disabled raises virtualization fault for a most-privileged switch
// - switch also faults unless translation on and tlb rights equal 7
// - switch enable bit 54 has no effect while virt_off_fn
// - features with presence 0 report state and control 0
// - feature writes change only implemented and controllable features
// - presence indication true whenever mode bit implemented
// - disabled indication true only when implemented and disabled
// - env query and setup report unimplemented while disabled
`timescale 1ns/10ps
module virtual_machine_disable_control #(
    parameter logic [virt_gate_pkg::feature_bits-1:0] impl_mask = 64'h0040_0100_0000_0000,
    parameter logic [virt_gate_pkg::feature_bits-1:0] ctrl_mask = 64'h0040_0100_0000_0000,
    parameter logic [virt_gate_pkg::feature_bits-1:0] status_init = 64'h0040_0100_0000_0000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic feature_write,
    input wire logic [virt_gate_pkg::feature_bits-1:0] feature_wdata,
    input wire virt_gate_pkg::switch_req_type switch_req,
    input wire logic env_call,
    output virt_gate_pkg::feature_vec_type features,
    output virt_gate_pkg::switch_resp_type switch_resp,
    output logic [1:0] env_status,
    output logic virt_present_fn,
    output logic virt_off_fn,
    output logic virt_mode_bit
);
    localparam int fw = virt_gate_pkg::feature_bits;
    localparam int vp = virt_gate_pkg::vm_feature_pos;
    localparam int sp = virt_gate_pkg::vmsw_enable_pos;

    // feature settings and report
    logic [fw-1:0] setting;
    logic [fw-1:0] writable;
    logic [fw-1:0] next_setting;
    logic [fw-1:0] shown;
    logic [fw-1:0] report_status;
    logic [fw-1:0] report_control;

    // gate state
    logic vm_impl;
    logic vm_off;
    logic disable_req;
    logic vm_live;
    logic vmsw_set;
    logic vmsw_live;
    logic env_refused;
    logic [1:0] next_env_status;

    // switch decision
    logic translation_ok;
    logic switch_blocked;
    virt_gate_pkg::fault_type fault;
    virt_gate_pkg::switch_resp_type next_switch_resp;

    assign vm_impl = impl_mask[vp];

    // vm bit stops being controllable once disabled
    always_comb begin
        writable = impl_mask & ctrl_mask;
        if (vm_off) begin
            writable[vp] = 1'b0;
        end
    end

    assign disable_req = feature_write && writable[vp] && !feature_wdata[vp];
    assign next_setting = (setting & ~writable) | (feature_wdata & writable);

    // report follows a write at the edge that takes it
    assign shown = feature_write ? next_setting : setting;
    assign vm_live = vm_impl && !vm_off && !disable_req;

    // switch enable only counts while vm features are on
    assign vmsw_set = impl_mask[sp] && setting[sp];
    assign vmsw_live = vmsw_set && !vm_off;
    assign env_refused = vm_off || !vm_impl;

    // one-way disable, cleared only by reset
    sticky_disable u_sticky (
        .clock(clock),
        .rst_n(rst_n),
        .set(disable_req),
        .flag(vm_off)
    );

    // feature settings held between writes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            setting <= status_init & impl_mask;
        end else if (feature_write) begin
            setting <= next_setting;
        end
    end

    // status and control vectors with the vm bit override
    always_comb begin
        report_status = shown & impl_mask;
        report_control = impl_mask & ctrl_mask;
        report_status[vp] = vm_live;
        report_control[vp] = vm_live && ctrl_mask[vp];
    end

    // registered feature report
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            features.avail <= virt_gate_pkg::status_reset;
            features.status <= virt_gate_pkg::status_reset;
            features.control <= virt_gate_pkg::status_reset;
        end else begin
            features.avail <= impl_mask;
            features.status <= report_status;
            features.control <= report_control;
        end
    end

    // presence indication
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            virt_present_fn <= 1'b0;
        end else begin
            virt_present_fn <= vm_impl;
        end
    end

    // disabled indication
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            virt_off_fn <= 1'b0;
        end else begin
            virt_off_fn <= vm_impl && (vm_off || disable_req);
        end
    end

    // vm mode bit usable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            virt_mode_bit <= 1'b0;
        end else begin
            virt_mode_bit <= vm_live;
        end
    end

    // env call answer
    always_comb begin
        next_env_status = env_status;
        if (env_call) begin
            if (env_refused) begin
                next_env_status = virt_gate_pkg::status_unimpl;
            end else begin
                next_env_status = virt_gate_pkg::status_ok;
            end
        end
    end

    // env status holds until the next call
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            env_status <= virt_gate_pkg::status_ok;
        end else begin
            env_status <= next_env_status;
        end
    end

    // switch fault decision
    // illegal operation outranks every virtualization fault
    // translation and rights are checked at every level
    always_comb begin
        translation_ok = switch_req.instr_translation_on
            && switch_req.instr_tlb_rights == virt_gate_pkg::rights_full;
        switch_blocked = !vmsw_live && switch_req.most_privileged;
        fault = virt_gate_pkg::fault_none;
        if (!vm_impl) begin
            fault = virt_gate_pkg::fault_illegal_op;
        end else if (!translation_ok) begin
            fault = virt_gate_pkg::fault_virtualization;
        end else if (switch_blocked) begin
            fault = virt_gate_pkg::fault_virtualization;
        end
    end

    // response flags for the request taken this cycle
    always_comb begin
        next_switch_resp = '0;
        next_switch_resp.valid = switch_req.valid;
        case (fault)
            virt_gate_pkg::fault_none: begin
                next_switch_resp.illegal_op = 1'b0;
            end
            virt_gate_pkg::fault_illegal_op: begin
                next_switch_resp.illegal_op = switch_req.valid;
            end
            virt_gate_pkg::fault_virtualization: begin
                next_switch_resp.virt_fault = switch_req.valid;
            end
            default: begin
                next_switch_resp.illegal_op = 1'b0;
                next_switch_resp.virt_fault = 1'b0;
            end
        endcase
    end

    // registered switch response
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            switch_resp <= '0;
        end else begin
            switch_resp <= next_switch_resp;
        end
    end
endmodule // virtual_machine_disable_control

// ### verification/virt_gate_props.sv
// assertions on the vm feature gate ports
// assumes default masks, bits 40 and 54 implemented
`timescale 1ns/10ps
module virt_gate_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic feature_write,
    input wire logic [virt_gate_pkg::feature_bits-1:0] feature_wdata,
    input wire virt_gate_pkg::switch_req_type switch_req,
    input wire logic env_call,
    input wire virt_gate_pkg::feature_vec_type features,
    input wire virt_gate_pkg::switch_resp_type switch_resp,
    input wire logic [1:0] env_status,
    input wire logic virt_present_fn,
    input wire logic virt_off_fn
);
    logic [1:0] age;
    always_ff @(posedge clock) age <= !rst_n ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || age != 2'h3);
    a_state_needs_mode: assert property (features.status[40] |-> virt_present_fn) else $error("s");
    a_off_reads_zero: assert property (virt_off_fn |-> !features.status[40]
        && !features.control[40] && features.avail[40]) else $error("off read");
    a_off_sticks: assert property (virt_off_fn |=> virt_off_fn) else $error("off lost");
    a_zero_write_off: assert property (feature_write && !feature_wdata[40]
        && features.control[40] |=> virt_off_fn) else $error("no disable");
    a_bad_rights: assert property (switch_req.valid && switch_req.instr_tlb_rights != 3'h7
        |=> switch_resp.valid && switch_resp.virt_fault) else $error("rights");
    a_off_switch: assert property (switch_req.valid && switch_req.most_privileged
        && virt_off_fn |=> switch_resp.virt_fault) else $error("off switch");
    a_env_unimpl: assert property (env_call && virt_off_fn |=> env_status == 2'h1) else $error("e");
    a_unimpl_zero: assert property (((features.status | features.control)
        & ~features.avail) == 64'h0) else $error("unimpl bits");
    a_present_level: assert property (virt_present_fn == features.avail[40]) else $error("p");
    cover property (env_call && virt_off_fn);
    cover property (switch_resp.virt_fault);
    cover property (feature_write && !feature_wdata[40]);
endmodule // virt_gate_props

// ### verification/virtual_machine_disable_control_tb.sv
// self-checking bench for the vm feature gate
// assumes default masks and the one-cycle answer of the design
`timescale 1ns/10ps
module virtual_machine_disable_control_tb;
    logic clock = 0, rst_n = 0, feature_write = 0, env_call = 0, off, flt;
    logic [63:0] feature_wdata = 64'h0, st, msk = 64'h0040_0100_0000_0000;
    virt_gate_pkg::switch_req_type switch_req = '0;
    virt_gate_pkg::feature_vec_type features;
    virt_gate_pkg::switch_resp_type switch_resp;
    logic [1:0] env_status;
    logic virt_present_fn, virt_off_fn, virt_mode_bit;
    int n_fail = 0, checks = 0, seed = 32'h7f5f, k;
    always #50 clock = ~clock;
    virtual_machine_disable_control virtual_machine_disable_control_i (.clock(clock),
        .rst_n(rst_n), .feature_write(feature_write), .feature_wdata(feature_wdata),
        .switch_req(switch_req), .env_call(env_call), .features(features),
        .switch_resp(switch_resp), .env_status(env_status), .virt_present_fn(virt_present_fn),
        .virt_off_fn(virt_off_fn), .virt_mode_bit(virt_mode_bit));
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input logic w, input logic [63:0] d, input logic e, input logic [5:0] s);
        @(posedge clock);
        feature_write <= w;
        feature_wdata <= d;
        env_call <= e;
        switch_req <= s;
        @(posedge clock);
        feature_write <= 1'b0;
        env_call <= 1'b0;
        switch_req <= '0;
        flt = !(s[3] && s[2:0] == 3'h7) || s[4] && (off || !st[54]);
        if (w) begin
            off = off | !d[40];
            st = (d & msk) | (st & ~msk);
            st[40] = !off;
        end
        #1;
        chk("status", features.status, st);
        chk("control", features.control, off ? msk & ~(64'h1 << 40) : msk);
        chk("avail", features.avail, msk);
        chk("off", virt_off_fn, off);
        chk("present", virt_present_fn, 1'b1);
        chk("mode", virt_mode_bit, !off);
        if (s[5]) chk("fault", {switch_resp.valid, switch_resp.illegal_op, switch_resp.virt_fault}, {2'h2, flt});
        if (e) chk("env", env_status, off ? virt_gate_pkg::status_unimpl : virt_gate_pkg::status_ok);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic start;
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        st = msk;
        off = 1'b0;
    endtask
    initial begin
        start();
        cyc(1'b0, 64'h0, 1'b1, 6'h3f);
        for (k = 0; k < 16; k++) cyc(k[0], {$random(seed), $random(seed)} | (64'h1 << 40), 1'b0, 6'h20 | 6'($random(seed)));
        $display("test random writes and switches done");
        cyc(1'b1, 64'h0, 1'b0, 6'h0);
        for (k = 0; k < 8; k++) cyc(1'b1, '1, k[0], {1'b1, k[0], 4'hf});
        $display("test one-way disable done");
        start();
        cyc(1'b0, 64'h0, 1'b1, 6'h3f);
        $display("test reset restore done");
        wrap_up();
    end
endmodule // virtual_machine_disable_control_tb
bind virtual_machine_disable_control virt_gate_props virt_gate_props_i (.clock(clock), .rst_n(rst_n),
    .feature_write(feature_write), .feature_wdata(feature_wdata), .switch_req(switch_req),
    .env_call(env_call), .features(features), .switch_resp(switch_resp),
    .env_status(env_status), .virt_present_fn(virt_present_fn), .virt_off_fn(virt_off_fn));
